// ---- sdc_defs.vh ----
// sdc_defs.vh: register map, field positions and sizes for the
// sample clock and buffer controller; assumes a 32-bit register bus
`ifndef SDC_DEFS_VH
`define SDC_DEFS_VH
// ==========================================
// register byte offsets
`define SDC_BCR 8'h00
`define SDC_RATE0 8'h04
`define SDC_GSRC 8'h14
`define SDC_CDIV0 8'h18
`define SDC_FDATA 8'h28
`define SDC_THR 8'h2c
`define SDC_STAT 8'h30
`define SDC_ISTAT 8'h34
`define SDC_IMASK 8'h38
`define SDC_DMA 8'h3c
// ==========================================
// control fields
`define SDC_BCR_HWSYNC 3:0
`define SDC_BCR_FMT 4
`define SDC_BCR_SWSYNC 5
`define SDC_GSRC_CKOUT 14:12
`define SDC_SRC_EXT 3'h4
// ==========================================
// sizes and reset values
`define SDC_PRESCALE 7'h7f
`define SDC_FIFO_DEPTH 19'h40000
`define SDC_THR_MAX 18'h3fffe
`define SDC_RATE_RST 16'h8000
`define SDC_DIV_RST 5'h00
// ==========================================
// interrupt status bits
`define SDC_IRQ_THR 0
`define SDC_IRQ_OVF 1
`define SDC_IRQ_SYNC 2
`endif

// ---- sdc_top.v ----
// sdc_top.v: sample clock generation, channel tagging, sample FIFO,
// threshold interrupt, dma requests and an AXI4-Lite register slave.
// assumes converters present data on adc_data when strobed, and that
// ext_clk_in and sync_in arrive asynchronously to aclk.
//
// Behaviour
// R1: four groups of four, any rate generator
// R2: per channel divisor from 1 to 32
// R3: rate generators divided by fixed 128
// R4: external clock selectable as group source
// R5: clock output from external or generator
// R6: group sync by software or hw input
// R7: sync passed onward on sync output
// R8: offset binary or two's complement format
// R9: four-bit channel tag on every sample
// R10: 256k by 20-bit sample FIFO
// R11: flag when count exceeds threshold
// R12: threshold flag raises interrupt request
// R13: host derives empty/full from threshold; thr clamps at 0x3fffe, so the flag can mark empty (thr 0) but not full
// R14: 32-bit host data agent
// R15: one shared interrupt, two dma channels
// R16: tag is channel number above data
`timescale 1ns/1ps
`include "sdc_defs.vh"

module sdc_top
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // converters
  output reg [15:0] conv_strobe,
  input wire [255:0] adc_data,
  // chaining pins
  input wire ext_clk_in,
  input wire sync_in,
  output reg clk_out,
  output reg sync_out,
  // host side
  output wire irq,
  output wire [1:0] dma_req
);

  // ==========================================
  // lowest set bit of a pending vector
  function [3:0] first_set;
    input [15:0] v;
    integer i;
    begin
      first_set = 4'h0;
      for (i = 15; i >= 0; i = i - 1)
        if (v[i])
          first_set = i[3:0];
    end
  endfunction

  // ==========================================
  // registers
  reg [3:0] hw_sync_sel;
  reg fmt_twos;
  reg [15:0] rate [0:3];
  reg [14:0] gsrc;
  reg [31:0] cdiv [0:3];
  reg [17:0] thr;
  reg [2:0] istat;
  reg [2:0] imask;
  reg [3:0] dma_ctl;
  reg sw_sync;

  // ==========================================
  // pin synchronisers
  reg eck_s1, eck_s2, eck_s3;
  reg syn_s1, syn_s2, syn_s3;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      eck_s1 <= 1'b0;
      eck_s2 <= 1'b0;
      eck_s3 <= 1'b0;
      syn_s1 <= 1'b0;
      syn_s2 <= 1'b0;
      syn_s3 <= 1'b0;
    end
    else
    begin
      eck_s1 <= ext_clk_in;
      eck_s2 <= eck_s1;
      eck_s3 <= eck_s2;
      syn_s1 <= sync_in;
      syn_s2 <= syn_s1;
      syn_s3 <= syn_s2;
    end
  end
  wire ext_rise = eck_s2 & ~eck_s3;
  wire hw_sync = syn_s2 & ~syn_s3;

  // ==========================================
  // rate generators and prescalers
  // sources 0..3 internal, 4 external
  reg [16:0] acc [0:3];
  reg [3:0] rg_tgl;
  reg [6:0] pre [0:4];
  wire [4:0] raw_tick;
  wire [4:0] src_tick;
  assign raw_tick[4] = ext_rise;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : rg
      // nco stands in for the tunable oscillator
      assign raw_tick[g] = acc[g][16];
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          acc[g] <= 17'h00000;
          rg_tgl[g] <= 1'b0;
        end
        else
        begin
          acc[g] <= {1'b0, acc[g][15:0]} + {1'b0, rate[g]};
          if (acc[g][16])
            rg_tgl[g] <= ~rg_tgl[g];
        end
      end
    end
    for (g = 0; g < 5; g = g + 1)
    begin : ps
      // R3: divide by 128
      assign src_tick[g] = raw_tick[g] & (pre[g] == `SDC_PRESCALE);
      always @(posedge aclk)
      begin
        if (!aresetn)
          pre[g] <= 7'h00;
        else if (raw_tick[g])
          pre[g] <= pre[g] + 7'h01;
      end
    end
  endgenerate

  // ==========================================
  // group sync and channel dividers
  reg [3:0] run;
  reg [4:0] ccnt [0:15];
  reg [15:0] hold [0:15];
  reg [15:0] pend;
  wire [3:0] gsync;
  wire [15:0] strobe;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : grp
      // R6: per group sync source
      assign gsync[g] = hw_sync_sel[g] ? hw_sync : sw_sync;
      always @(posedge aclk)
      begin
        if (!aresetn)
          run[g] <= 1'b0;
        else if (gsync[g])
          run[g] <= 1'b1;
      end
    end
    for (g = 0; g < 16; g = g + 1)
    begin : ch
      wire [2:0] s = gsrc[3*(g/4)+2 -: 3];
      wire [4:0] dv = cdiv[g/4][8*(g%4)+4 -: 5];
      // R1: group picks its source
      // R4: external clock as source
      wire tk = (s > `SDC_SRC_EXT) ? 1'b0 : src_tick[s];
      // R2: divide by dv+1
      assign strobe[g] = run[g/4] & tk & (ccnt[g] == 5'h00);
      always @(posedge aclk)
      begin
        if (!aresetn)
          ccnt[g] <= 5'h00;
        else if (gsync[g/4])
          ccnt[g] <= 5'h00;
        else if (run[g/4] & tk)
          ccnt[g] <= (ccnt[g] == dv) ? 5'h00 : ccnt[g] + 5'h01;
      end
      always @(posedge aclk)
      begin
        if (!aresetn)
          hold[g] <= 16'h0000;
        else if (strobe[g])
          // R8: flip msb for two's complement
          hold[g] <= {adc_data[16*g+15] ^ fmt_twos, adc_data[16*g+14 -: 15]};
      end
    end
  endgenerate

  // ==========================================
  // sample fifo
  reg [19:0] mem [0:262143];
  reg [17:0] wp, rp;
  reg [18:0] cnt;
  wire full = (cnt == `SDC_FIFO_DEPTH);
  wire empty = (cnt == 19'h00000);
  wire [3:0] sel = first_set(pend);
  wire push = (|pend) & ~full;
  wire pop;
  // R11: strictly greater than threshold
  wire flag = (cnt > {1'b0, thr});
  reg flag_d;
  // pending bits: a new strobe wins over the drain
  always @(posedge aclk)
  begin
    if (!aresetn)
      pend <= 16'h0000;
    else
      pend <= (pend & ~((|pend) ? (16'h0001 << sel) : 16'h0000)) | strobe;
  end
  always @(posedge aclk)
  begin
    if (push)
      // R9: tag every entry
      // R16: channel number above data
      // R10: store 20-bit entry
      mem[wp] <= {sel, hold[sel]};
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wp <= 18'h00000;
      rp <= 18'h00000;
      cnt <= 19'h00000;
      flag_d <= 1'b0;
      conv_strobe <= 16'h0000;
    end
    else
    begin
      conv_strobe <= strobe;
      flag_d <= flag;
      if (push)
        wp <= wp + 18'h00001;
      if (pop)
        rp <= rp + 18'h00001;
      if (push & ~pop)
        cnt <= cnt + 19'h00001;
      else if (pop & ~push)
        cnt <= cnt - 19'h00001;
    end
  end

  // ==========================================
  // chain outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_out <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      // R5: output clock source
      clk_out <= (gsrc[14:12] == `SDC_SRC_EXT) ? eck_s2 : rg_tgl[gsrc[13:12]];
      // R7: pass sync onward
      sync_out <= hw_sync | sw_sync;
    end
  end

  // ==========================================
  // interrupts and dma
  wire [2:0] ev = {hw_sync, (|pend) & full, flag & ~flag_d};
  // R12: threshold event
  // R15: one shared interrupt line
  assign irq = |(istat & imask);
  // R15: demand follows flag, block drains
  assign dma_req[0] = dma_ctl[0] & (dma_ctl[1] ? flag : ~empty);
  assign dma_req[1] = dma_ctl[2] & (dma_ctl[3] ? flag : ~empty);

  // ==========================================
  // axi4-lite slave
  // R14: 32-bit register agent
  reg aw_ok, w_ok;
  reg [7:0] awa;
  reg [31:0] wd;
  wire do_wr = aw_ok & w_ok & ~s_axi_bvalid;
  assign s_axi_awready = ~aw_ok & ~s_axi_bvalid;
  assign s_axi_wready = ~w_ok & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire do_rd = s_axi_arvalid & ~s_axi_rvalid;
  wire [7:0] ra = s_axi_araddr;
  assign pop = do_rd & (ra == `SDC_FDATA) & ~empty;
  integer k;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ok <= 1'b0;
      w_ok <= 1'b0;
      awa <= 8'h00;
      wd <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      hw_sync_sel <= 4'h0;
      fmt_twos <= 1'b0;
      sw_sync <= 1'b0;
      gsrc <= 15'h0000;
      thr <= 18'h00000;
      istat <= 3'h0;
      imask <= 3'h0;
      dma_ctl <= 4'h0;
      for (k = 0; k < 4; k = k + 1)
      begin
        rate[k] <= `SDC_RATE_RST;
        cdiv[k] <= 32'h00000000;
      end
    end
    else
    begin
      sw_sync <= 1'b0;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_ok <= 1'b1;
        awa <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_ok <= 1'b1;
        wd <= s_axi_wdata;
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // sticky events; set wins over clear
      istat <= (istat & ~((do_wr & (awa == `SDC_ISTAT)) ? wd[2:0] : 3'h0)) | ev;
      if (do_wr)
      begin
        aw_ok <= 1'b0;
        w_ok <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (awa == `SDC_BCR)
        begin
          hw_sync_sel <= wd[`SDC_BCR_HWSYNC];
          fmt_twos <= wd[`SDC_BCR_FMT];
          sw_sync <= wd[`SDC_BCR_SWSYNC];
        end
        else if (awa >= `SDC_RATE0 && awa < `SDC_GSRC && awa[1:0] == 2'h0)
          rate[awa[3:2] - 2'h1] <= wd[15:0];
        else if (awa == `SDC_GSRC)
          gsrc <= wd[14:0];
        else if (awa >= `SDC_CDIV0 && awa < `SDC_FDATA && awa[1:0] == 2'h0)
          cdiv[awa[3:2] - 2'h2] <= wd & 32'h1f1f1f1f;
        else if (awa == `SDC_THR)
          // R13: host programs threshold
          thr <= (wd[17:0] > `SDC_THR_MAX) ? `SDC_THR_MAX : wd[17:0];
        else if (awa == `SDC_IMASK)
          imask <= wd[2:0];
        else if (awa == `SDC_DMA)
          dma_ctl <= wd[3:0];
        else if (awa != `SDC_ISTAT)
          s_axi_bresp <= 2'h2;
      end
    end
  end

  // read side; fifo reads pop, empty reads zero
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else if (do_rd)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
      if (ra == `SDC_BCR)
        s_axi_rdata <= {26'h0, 1'b0, fmt_twos, hw_sync_sel};
      else if (ra >= `SDC_RATE0 && ra < `SDC_GSRC && ra[1:0] == 2'h0)
        s_axi_rdata <= {16'h0000, rate[ra[3:2] - 2'h1]};
      else if (ra == `SDC_GSRC)
        s_axi_rdata <= {17'h00000, gsrc};
      else if (ra >= `SDC_CDIV0 && ra < `SDC_FDATA && ra[1:0] == 2'h0)
        s_axi_rdata <= cdiv[ra[3:2] - 2'h2];
      else if (ra == `SDC_FDATA)
        s_axi_rdata <= empty ? 32'h00000000 : {12'h000, mem[rp]};
      else if (ra == `SDC_THR)
        s_axi_rdata <= {14'h0000, thr};
      else if (ra == `SDC_STAT)
        s_axi_rdata <= {run, 1'b0, full, empty, flag, 5'h00, cnt};
      else if (ra == `SDC_ISTAT)
        s_axi_rdata <= {29'h0, istat};
      else if (ra == `SDC_IMASK)
        s_axi_rdata <= {29'h0, imask};
      else if (ra == `SDC_DMA)
        s_axi_rdata <= {28'h0, dma_ctl};
      else
        s_axi_rresp <= 2'h2;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // sdc_top

// ---- sdc_top_sva.sv ----
// sdc_top_sva.sv: port checks for sdc_top, bound at the foot
// assumes one aclk domain, synchronous active-low aresetn
`timescale 1ns/1ps
module sdc_top_sva
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // sampling and chain
  input wire [15:0] conv_strobe,
  input wire sync_in,
  input wire sync_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ====
  // bus
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
  wr_block_a: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no read answer");
  // ====
  // sampling and chain
  strobe_pulse_a: assert property ((|conv_strobe[3:0]) |=> !(|conv_strobe[3:0]))
    else $error("group strobe too long");
  sync_pulse_a: assert property (sync_out |=> !sync_out)
    else $error("sync out too long");
  sync_fwd_a: assert property ($rose(sync_in) |-> ##[2:6] sync_out)
    else $error("sync not passed on");
  c_wr_c: cover property (s_axi_bvalid && s_axi_bready);
  c_st_c: cover property (conv_strobe[3]);
  c_sy_c: cover property (sync_out);
endmodule // sdc_top_sva
bind sdc_top sdc_top_sva i_sva
(
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata),
  .conv_strobe(conv_strobe),
  .sync_in(sync_in),
  .sync_out(sync_out)
);

// ---- sdc_far_model.sv ----
// sdc_far_model.sv: converters, upstream link clock and sync
// assumes the bench sets base, clk_en and sync_req
`timescale 1ns/1ps
module sdc_far_model
(
  // from bench
  input wire [15:0] base,
  input wire clk_en,
  input wire sync_req,
  // to block
  output logic [255:0] adc_data,
  output logic ext_clk_in,
  output wire sync_in
);
  // ====
  // channel n reads base plus n
  always_comb
    for (int n = 0; n < 16; n++)
      adc_data[16*n+:16] = base + 16'(n);
  // ====
  // link clock, odd phase to aclk, still when off
  initial
  begin
    ext_clk_in = 1'b0;
    #37;
    forever #400 ext_clk_in = clk_en && !ext_clk_in;
  end
  assign sync_in = sync_req;
endmodule // sdc_far_model

// ---- testbench.sv ----
// testbench.sv: self-checking bench for sdc_top
// assumes sdc_far_model on the converter and link side
`timescale 1ns/1ps
`include "sdc_defs.vh"
module testbench;
  // ====
  // signals
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b0, sync_req = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [15:0] base = 16'h0;
  logic [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, dma_req;
  wire [31:0] s_axi_rdata;
  wire [15:0] conv_strobe;
  wire [255:0] adc_data;
  wire ext_clk_in, sync_in, clk_out, sync_out, irq;
  int num_errors = 0, num_checks = 0, clk_edges = 0, syncs = 0, n;
  int dv [4];
  int q [$];
  logic ck_q = 1'b0;
  int rises = 0, per = 0;
  sdc_top i_dut
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .conv_strobe(conv_strobe), .adc_data(adc_data), .ext_clk_in(ext_clk_in),
    .sync_in(sync_in), .clk_out(clk_out), .sync_out(sync_out), .irq(irq), .dma_req(dma_req)
  );
  sdc_far_model i_far
  (
    .base(base), .clk_en(clk_en), .sync_req(sync_req), .adc_data(adc_data),
    .ext_clk_in(ext_clk_in), .sync_in(sync_in)
  );
  always #50 aclk = !aclk;
  always @(posedge clk_out) clk_edges++;
  always @(posedge aclk) syncs += sync_out;
  // clk_out rises between two channel 0 strobes; divisor 1 gives 128 toggles
  always @(posedge aclk)
  begin
    ck_q <= clk_out;
    if (conv_strobe[0])
      per <= rises;
    rises <= (conv_strobe[0] ? 0 : rises) + int'(clk_out && !ck_q);
  end
  // ====
  // checks and bus cycles
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] s, input string w);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic tmo(input int i, input int m);
    if (i >= m)
    begin
      chk(1, 0, "wait");
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e = 2'h0);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // bready sometimes late, so bvalid must hold
    s_axi_bready <= ($urandom_range(0, 3) != 0);
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
        break;
      if (s_axi_bvalid)
        s_axi_bready <= 1'b1;
    end
    tmo(i, 50);
    chk(e, s_axi_bresp, "bresp");
  endtask
  task automatic rd(input logic [7:0] a);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    // rready sometimes late, so rvalid and rdata must hold
    s_axi_rready <= ($urandom_range(0, 3) != 0);
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
        break;
      if (s_axi_rvalid)
        s_axi_rready <= 1'b1;
    end
    tmo(i, 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic wait_cnt(input int lo);
    int i;
    for (i = 0; i < 3000; i++)
    begin
      rd(`SDC_STAT);
      if (d[18:0] > lo)
        break;
    end
    tmo(i, 3000);
  endtask
  // two's complement is offset binary with msb flipped
  function automatic logic [31:0] exp_word(input int c, input logic f);
    logic [15:0] v;
    v = base + 16'(c);
    v[15] = v[15] ^ f;
    return {12'h0, 4'(c), v};
  endfunction
  // ====
  // sequence
  initial
  begin
    n = $urandom(39);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`SDC_RATE0);
    chk(`SDC_RATE_RST, d, "rate0");
    rd(`SDC_STAT);
    chk(32'h02000000, d & 32'hf707ffff, "stat");
    wr(8'h40, 32'h1, 2'h2);
    wr(`SDC_STAT, 32'h1, 2'h2);
    rd(8'h44);
    chk(32'h0, d, "bad rdata");
    chk(32'h2, r, "bad rresp");
    wr(`SDC_THR, 32'h3fffe + $urandom_range(0, 1));
    rd(`SDC_THR);
    chk(`SDC_THR_MAX, d, "thr max");
    $display("regs done");
    for (int f = 0; f < 2; f++)
    begin
      base <= 16'($urandom);
      // divisor 1 and 32 corners, two random
      dv = '{1, 32, $urandom_range(1, 32), $urandom_range(1, 32)};
      q = {};
      for (int k = 0; k < 64; k++)
        for (int c = 0; c < 4; c++)
          if (k % dv[c] == 0)
            q.push_back(c);
      wr(`SDC_THR, 32'd5);
      wr(`SDC_IMASK, 32'h1);
      wr(`SDC_ISTAT, 32'h7);
      wr(`SDC_DMA, 32'h1);
      wr(`SDC_CDIV0, {3'h0, 5'(dv[3] - 1), 3'h0, 5'(dv[2] - 1),
        3'h0, 5'(dv[1] - 1), 3'h0, 5'(dv[0] - 1)});
      // group 0 on generator f, synced while its source is off
      wr(`SDC_RATE0 + 8'(4 * f), 32'hffff);
      wr(`SDC_GSRC, 32'h0b6d);
      wr(`SDC_BCR, 32'h20 | (f << 4));
      wr(`SDC_GSRC, 32'h0b68 | f | (f << 12));
      wait_cnt(24);
      chk(64, per, "prescale");
      chk(1, d[24], "thr flag");
      chk(1, irq, "irq");
      wr(`SDC_IMASK, 32'h0);
      chk(0, irq, "irq masked");
      wr(`SDC_IMASK, 32'h1);
      wr(`SDC_DMA, 32'hf);
      chk(3, dma_req, "dma both");
      wr(`SDC_ISTAT, 32'h1);
      chk(0, irq, "irq clear");
      wr(`SDC_GSRC, 32'h0b6d);
      wr(`SDC_DMA, 32'h1);
      repeat (20) @(posedge aclk);
      rd(`SDC_STAT);
      n = d[18:0];
      for (int i = 0; i < n && i < q.size(); i++)
      begin
        chk(1, dma_req[0], "dma block");
        rd(`SDC_FDATA);
        chk(exp_word(q[i], f[0]), d, "fifo word");
      end
      rd(`SDC_STAT);
      chk(32'h02000000, d & 32'h0707ffff, "drained");
      chk(0, dma_req, "dma idle");
      chk(1, clk_edges > 0, "clk out gen");
      chk(1, syncs > 0, "sync out sw");
      $display("run %0d done", f);
    end
    // second reset in mid-run, then external clock and hw sync
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    clk_en <= 1'b1;
    clk_edges = 0;
    wr(`SDC_GSRC, 32'h4b6c);
    wr(`SDC_BCR, 32'h1);
    rd(`SDC_STAT);
    chk(0, d[28], "idle group");
    n = syncs;
    sync_req <= 1'b1;
    repeat (20) @(posedge aclk);
    sync_req <= 1'b0;
    wait_cnt(0);
    chk(1, d[28], "group runs");
    chk(1, syncs > n, "sync out hw");
    rd(`SDC_ISTAT);
    chk(1, d[2], "hw sync");
    chk(1, clk_edges > 4, "clk out ext");
    rd(`SDC_FDATA);
    chk(exp_word(0, 1'b0), d, "ext word");
    $display("ext done");
    report_and_stop();
  end
endmodule // testbench
